// [hdl/sarc_pkg.sv]
// sar converter control: register map, timing counts and shared types
// Function
// - start write begins conversion, clears complete flag
// - finished conversion sets complete flag
// - one conversion per start request
// - start during conversion restarts immediately
// - start bit reads back as zero
// - complete flag raises end-of-conversion interrupt; here status bit 0, set by the finish event, raises it instead
// - top control bit gates that interrupt
// - power select low idles the converter
// - reset aborts, control 40h, interrupt masked
// - step clock is oscillator divided by twelve
// - conversion lasts about 70us at 8MHz
// - result register read-only, eight bits
// - complete flag read-only, usable as pending
// - converter keeps running in wait state
package sarc_pkg;

    // -------------------------------------------------------------
    // register map
    // -------------------------------------------------------------
    localparam logic [7:0] SARC_RESULT_ADDR = 8'hD0;
    localparam logic [7:0] SARC_CTRL_ADDR = 8'hD1;
    localparam logic [7:0] SARC_STATUS_ADDR = 8'hD2;
    localparam logic [7:0] SARC_MASK_ADDR = 8'hD3;

    localparam int SARC_IRQ_EN_POS = 7;
    localparam int SARC_DONE_POS = 6;
    localparam int SARC_START_POS = 5;
    localparam int SARC_POWER_POS = 4;

    localparam int SARC_EV_DONE_POS = 0;
    localparam int SARC_EV_ABORT_POS = 1;

    localparam logic [7:0] SARC_CTRL_RESET = 8'h40;
    localparam logic [7:0] SARC_STATUS_RESET = 8'h00;
    localparam logic [7:0] SARC_MASK_RESET = 8'h00;
    localparam logic [7:0] SARC_RESULT_RESET = 8'h00;

    // -------------------------------------------------------------
    // timing
    // -------------------------------------------------------------
    localparam int SARC_CONV_DIV = 12;
    localparam int SARC_CONV_TIME_NS = 70000;
    localparam int SARC_OSC_REF_KHZ = 8000;
    localparam int SARC_CONV_TICKS =
        (SARC_CONV_TIME_NS * SARC_OSC_REF_KHZ) / (1000000 * SARC_CONV_DIV);
    localparam int SARC_RES_BITS = 8;
    localparam int SARC_BIT_TICKS = SARC_CONV_TICKS / SARC_RES_BITS;
    localparam int SARC_ACQ_TICKS = SARC_CONV_TICKS - SARC_BIT_TICKS * SARC_RES_BITS;

    // -------------------------------------------------------------
    // types
    // -------------------------------------------------------------
    typedef enum logic [2:0] {
        SARC_IDLE = 3'b001,
        SARC_ACQUIRE = 3'b010,
        SARC_APPROX = 3'b100
    } sarc_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } sarc_bus_req_t;

    typedef struct packed {
        logic irq_en;
        logic done;
        logic power;
    } sarc_ctrl_t;

endpackage : sarc_pkg

// [hdl/sarc_sequencer.sv]
// sar converter sequencer with control, result, status and mask registers
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module sarc_sequencer
    import sarc_pkg::*;
#(
    parameter int CONV_DIV = SARC_CONV_DIV,
    parameter int ACQ_TICKS = SARC_ACQ_TICKS,
    parameter int BIT_TICKS = SARC_BIT_TICKS
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // register port
    input wire sarc_bus_req_t bus_req,
    output logic [7:0] rd_data,
    // analog front end
    input wire logic cmp_above,
    output logic [7:0] dac_code,
    output logic conv_sample,
    output logic adc_power,
    output logic conv_busy,
    // interrupt
    output logic irq
);

    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] target);
        addr_hit = (a == target);
    endfunction : addr_hit

    function automatic logic [7:0] bit_sel(input logic [2:0] idx);
        bit_sel = 8'(8'h01 << idx);
    endfunction : bit_sel

    // -------------------------------------------------------------
    // declarations
    // -------------------------------------------------------------
    sarc_ctrl_t ctrl;
    sarc_state_t state;
    logic [3:0] div_cnt;
    logic tick;
    logic cmp_s1;
    logic cmp_s2;
    logic cmp_s3;
    logic cmp_level;
    logic [3:0] phase_cnt;
    logic [2:0] bit_idx;
    logic [7:0] trial;
    logic [7:0] result;
    logic [7:0] status;
    logic [7:0] mask;
    logic wr_ctrl;
    logic wr_status;
    logic wr_mask;
    logic start_req;
    logic power_off;
    logic finish;
    logic abort_ev;
    logic [7:0] events;
    logic [7:0] eff_mask;
    logic [7:0] next_trial;
    logic [7:0] next_rd_data;

    // -------------------------------------------------------------
    // address decode
    // -------------------------------------------------------------
    assign wr_ctrl = bus_req.wr && addr_hit(bus_req.addr, SARC_CTRL_ADDR);
    assign wr_status = bus_req.wr && addr_hit(bus_req.addr, SARC_STATUS_ADDR);
    assign wr_mask = bus_req.wr && addr_hit(bus_req.addr, SARC_MASK_ADDR);

    // start only takes effect while powered; the power bit of the same
    // write counts, so one write can power up and start together
    assign start_req = wr_ctrl && bus_req.wdata[SARC_START_POS]
        && bus_req.wdata[SARC_POWER_POS];

    // a power-down write idles the sequencer on its own edge, not one cycle later
    assign power_off = wr_ctrl ? !bus_req.wdata[SARC_POWER_POS] : !ctrl.power;

    // -------------------------------------------------------------
    // conversion clock divider
    // -------------------------------------------------------------
    // free running, not gated by the cpu wait state
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            div_cnt <= 4'h0;
        end else if (div_cnt == 4'(CONV_DIV - 1)) begin
            div_cnt <= 4'h0;
        end else begin
            div_cnt <= div_cnt + 4'h1;
        end
    end

    assign tick = (div_cnt == 4'(CONV_DIV - 1));

    // -------------------------------------------------------------
    // comparator synchroniser
    // -------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cmp_s1 <= 1'b0;
            cmp_s2 <= 1'b0;
            cmp_s3 <= 1'b0;
        end else begin
            cmp_s1 <= cmp_above;
            cmp_s2 <= cmp_s1;
            cmp_s3 <= cmp_s2;
        end
    end

    // a change counts once two stages agree, filtering a single glitch
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cmp_level <= 1'b0;
        end else if (cmp_s2 == cmp_s3) begin
            cmp_level <= cmp_s3;
        end
    end

    // -------------------------------------------------------------
    // control register
    // -------------------------------------------------------------
    // one process for the whole struct; complete flag is hardware only
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl.irq_en <= SARC_CTRL_RESET[SARC_IRQ_EN_POS];
            ctrl.done <= SARC_CTRL_RESET[SARC_DONE_POS];
            ctrl.power <= SARC_CTRL_RESET[SARC_POWER_POS];
        end else begin
            if (wr_ctrl) begin
                ctrl.irq_en <= bus_req.wdata[SARC_IRQ_EN_POS];
                ctrl.power <= bus_req.wdata[SARC_POWER_POS];
            end
            if (start_req) begin
                ctrl.done <= 1'b0;
            end else if (finish) begin
                ctrl.done <= 1'b1;
            end
        end
    end

    // -------------------------------------------------------------
    // successive approximation sequencer
    // -------------------------------------------------------------
    // decide the current bit and try the next lower one
    always_comb begin
        next_trial = trial;
        if (cmp_level) begin
            next_trial = trial;
        end else begin
            next_trial = trial & ~bit_sel(bit_idx);
        end
        if (bit_idx != 3'h0) begin
            next_trial = next_trial | bit_sel(bit_idx - 3'h1);
        end
    end

    assign finish = (state == SARC_APPROX) && tick && !power_off && !start_req
        && (phase_cnt == 4'(BIT_TICKS - 1)) && (bit_idx == 3'h0);

    assign abort_ev = (state != SARC_IDLE) && (start_req || power_off);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= SARC_IDLE;
            phase_cnt <= 4'h0;
            bit_idx <= 3'h0;
            trial <= 8'h00;
        end else if (start_req) begin
            // a running conversion is dropped, not finished first
            state <= SARC_ACQUIRE;
            phase_cnt <= 4'h0;
            bit_idx <= 3'h7;
            trial <= 8'h00;
        end else if (power_off) begin
            state <= SARC_IDLE;
            phase_cnt <= 4'h0;
            trial <= 8'h00;
        end else if (tick) begin
            case (state)
                SARC_IDLE: begin
                    state <= SARC_IDLE;
                end
                SARC_ACQUIRE: begin
                    if (phase_cnt == 4'(ACQ_TICKS - 1)) begin
                        state <= SARC_APPROX;
                        phase_cnt <= 4'h0;
                        bit_idx <= 3'h7;
                        trial <= 8'h80;
                    end else begin
                        phase_cnt <= phase_cnt + 4'h1;
                    end
                end
                SARC_APPROX: begin
                    if (phase_cnt == 4'(BIT_TICKS - 1)) begin
                        phase_cnt <= 4'h0;
                        trial <= next_trial;
                        if (bit_idx == 3'h0) begin
                            state <= SARC_IDLE;
                        end else begin
                            bit_idx <= bit_idx - 3'h1;
                        end
                    end else begin
                        phase_cnt <= phase_cnt + 4'h1;
                    end
                end
                default: begin
                    state <= SARC_IDLE;
                    phase_cnt <= 4'h0;
                end
            endcase
        end
    end

    // -------------------------------------------------------------
    // result register
    // -------------------------------------------------------------
    // only complete results are stored, so a read never sees a partial code
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            result <= SARC_RESULT_RESET;
        end else if (finish) begin
            result <= next_trial;
        end
    end

    // -------------------------------------------------------------
    // events, status and mask
    // -------------------------------------------------------------
    always_comb begin
        events = 8'h00;
        events[SARC_EV_DONE_POS] = finish;
        events[SARC_EV_ABORT_POS] = abort_ev;
    end

    // a new event wins over a write-one clear in the same cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            status <= SARC_STATUS_RESET;
        end else if (wr_status) begin
            status <= (status & ~bus_req.wdata) | events;
        end else begin
            status <= status | events;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mask <= SARC_MASK_RESET;
        end else if (wr_mask) begin
            mask <= bus_req.wdata;
        end
    end

    // end-of-conversion source also needs the control enable bit
    always_comb begin
        eff_mask = mask;
        eff_mask[SARC_EV_DONE_POS] = mask[SARC_EV_DONE_POS] && ctrl.irq_en;
    end

    assign irq = |(status & eff_mask);

    // -------------------------------------------------------------
    // read port
    // -------------------------------------------------------------
    always_comb begin
        next_rd_data = 8'h00;
        case (1'b1)
            addr_hit(bus_req.addr, SARC_RESULT_ADDR): begin
                next_rd_data = result;
            end
            addr_hit(bus_req.addr, SARC_CTRL_ADDR): begin
                next_rd_data[SARC_IRQ_EN_POS] = ctrl.irq_en;
                next_rd_data[SARC_DONE_POS] = ctrl.done;
                next_rd_data[SARC_START_POS] = 1'b0;
                next_rd_data[SARC_POWER_POS] = ctrl.power;
            end
            addr_hit(bus_req.addr, SARC_STATUS_ADDR): begin
                next_rd_data = status;
            end
            addr_hit(bus_req.addr, SARC_MASK_ADDR): begin
                next_rd_data = mask;
            end
            default: begin
                next_rd_data = 8'h00;
            end
        endcase
    end

    // data stand only in the cycle after the read strobe
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_data <= 8'h00;
        end else if (bus_req.rd) begin
            rd_data <= next_rd_data;
        end else begin
            rd_data <= 8'h00;
        end
    end

    // -------------------------------------------------------------
    // analog side outputs
    // -------------------------------------------------------------
    assign dac_code = trial;
    assign conv_sample = (state == SARC_ACQUIRE);
    assign conv_busy = (state != SARC_IDLE);
    assign adc_power = ctrl.power;

endmodule : sarc_sequencer

`default_nettype wire

// [dv/sarc_analog_src.sv]
// analog source model on the one selected input pin
`timescale 1ns/1ps
`default_nettype none
module sarc_analog_src (
    // analog level of the selected pin
    input wire logic [7:0] vin,
    // converter side
    input wire logic [7:0] dac_code,
    input wire logic adc_power,
    output logic cmp_above
);
    // one pin feeds the comparator, never a mix of several
    // unpowered comparator answers nothing usable, so it toggles with the code
    assign cmp_above = adc_power ? (vin >= dac_code) : (dac_code[0] ^ vin[0]);
endmodule : sarc_analog_src
`default_nettype wire

// [dv/sarc_properties.sv]
// port-level checks for the sar sequencer
`timescale 1ns/1ps
`default_nettype none
module sarc_properties
    import sarc_pkg::*;
#(
    parameter int CONV_DIV = SARC_CONV_DIV,
    parameter int ACQ_TICKS = SARC_ACQ_TICKS,
    parameter int BIT_TICKS = SARC_BIT_TICKS
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // register port
    input wire sarc_bus_req_t bus_req,
    input wire logic [7:0] rd_data,
    // front end and interrupt
    input wire logic cmp_above,
    input wire logic [7:0] dac_code,
    input wire logic conv_sample,
    input wire logic adc_power,
    input wire logic conv_busy,
    input wire logic irq
);
    // margin covers the free divider phase
    localparam int MAX_BUSY = CONV_DIV * (ACQ_TICKS + 8 * BIT_TICKS + 1) + 8;
    int busy_cnt;
    logic ctrl_wr;
    logic start_wr;
    assign ctrl_wr = bus_req.wr && bus_req.addr == SARC_CTRL_ADDR;
    assign start_wr = ctrl_wr && bus_req.wdata[5] && bus_req.wdata[4];
    // any control write restarts the count, so a restart is not a long run
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) busy_cnt <= 0;
        else if (!conv_busy || ctrl_wr) busy_cnt <= 0;
        else busy_cnt <= busy_cnt + 1;
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    sequence ctrl_rd_s;
        bus_req.rd && bus_req.addr == SARC_CTRL_ADDR;
    endsequence
    sequence approx_entry_s;
        conv_sample ##1 (!conv_sample && conv_busy);
    endsequence
    a_start_busy: assert property (start_wr |=> conv_busy && conv_sample)
        else $error("start write began no conversion");
    a_power_follow: assert property (ctrl_wr |=> adc_power == $past(bus_req.wdata[4]))
        else $error("power output differs from written bit");
    a_power_read: assert property (ctrl_rd_s |=> rd_data[4] == adc_power)
        else $error("power bit read differs from power output");
    a_read_zero: assert property (ctrl_rd_s |=> rd_data[5] == 1'b0 && rd_data[3:0] == 4'h0)
        else $error("start or unused control bits read nonzero");
    a_pwr_down_idle: assert property (ctrl_wr && !bus_req.wdata[4]
        |=> !conv_busy && dac_code == 8'h00)
        else $error("power down left converter running");
    a_idle_stays: assert property (!conv_busy && !start_wr |=> !conv_busy)
        else $error("conversion began without a start write");
    a_sample_first: assert property ($rose(conv_busy) |-> conv_sample)
        else $error("conversion did not begin with sampling");
    a_approx_msb: assert property (approx_entry_s |-> dac_code == 8'h80)
        else $error("first trial code is not the top bit");
    a_busy_bound: assert property (busy_cnt <= MAX_BUSY)
        else $error("conversion ran longer than its tick count");
endmodule : sarc_properties
bind sarc_sequencer sarc_properties #(.CONV_DIV(CONV_DIV), .ACQ_TICKS(ACQ_TICKS),
    .BIT_TICKS(BIT_TICKS)) sarc_properties_i (.clk(clk), .rst_b(rst_b), .bus_req(bus_req),
    .rd_data(rd_data), .cmp_above(cmp_above), .dac_code(dac_code), .conv_sample(conv_sample),
    .adc_power(adc_power), .conv_busy(conv_busy), .irq(irq));
`default_nettype wire

// [dv/tb_top.sv]
// self-checking bench for the sar sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top import sarc_pkg::*;;
    // short counts keep the run brief; six clocks a bit let the
    // comparator synchroniser settle before each decision
    localparam int DIV = 3;
    localparam int ACQ = 1;
    localparam int BITT = 2;
    localparam int LO = (ACQ + 8 * BITT - 1) * DIV;
    localparam int HI = (ACQ + 8 * BITT) * DIV + 2;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    sarc_bus_req_t bus_req = '0;
    logic [7:0] vin = 8'h00;
    logic [7:0] rd_data;
    logic [7:0] dac_code;
    logic cmp_above;
    logic conv_sample;
    logic adc_power;
    logic conv_busy;
    logic irq;
    int bad_count = 0;
    int samples_checked = 0;
    always #5 clk = ~clk;
    sarc_sequencer #(.CONV_DIV(DIV), .ACQ_TICKS(ACQ), .BIT_TICKS(BITT)) sarc_sequencer_i (
        .clk(clk), .rst_b(rst_b), .bus_req(bus_req), .rd_data(rd_data),
        .cmp_above(cmp_above), .dac_code(dac_code), .conv_sample(conv_sample),
        .adc_power(adc_power), .conv_busy(conv_busy), .irq(irq));
    sarc_analog_src sarc_analog_src_i (.vin(vin), .dac_code(dac_code), .adc_power(adc_power),
        .cmp_above(cmp_above));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            bad_count++;
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus_req.wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus_req.rd <= 1'b0;
        #1;
        chk(rd_data, exp);
    endtask : rd
    // waits for the end of a conversion, then checks its length
    task automatic wait_idle();
        int n;
        n = 2;
        while (conv_busy !== 1'b0 && n < 1000) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(8'(n >= LO && n <= HI), 8'h01);
    endtask : wait_idle
    task automatic t_reset();
        chk({5'h00, irq, conv_busy, adc_power}, 8'h00);
        rd(SARC_CTRL_ADDR, 8'h40);
        rd(SARC_STATUS_ADDR, 8'h00);
        rd(SARC_RESULT_ADDR, 8'h00);
        rd(8'hD4, 8'h00);
    endtask : t_reset
    task automatic t_convert();
        logic [7:0] vals [4] = '{8'h00, 8'hFF, 8'h5A, 8'hA5};
        wr(SARC_CTRL_ADDR, 8'h10);
        foreach (vals[i]) begin
            vin = vals[i];
            wr(SARC_CTRL_ADDR, 8'h30);
            rd(SARC_CTRL_ADDR, 8'h10);
            wait_idle();
            rd(SARC_RESULT_ADDR, vals[i]);
            rd(SARC_CTRL_ADDR, 8'h50);
        end
    endtask : t_convert
    task automatic t_irq();
        wr(SARC_STATUS_ADDR, 8'hFF);
        wr(SARC_CTRL_ADDR, 8'h30);
        rd(SARC_CTRL_ADDR, 8'h10);
        wait_idle();
        rd(SARC_STATUS_ADDR, 8'h01);
        wr(SARC_MASK_ADDR, 8'h01);
        chk({7'h00, irq}, 8'h00);
        wr(SARC_CTRL_ADDR, 8'h90);
        chk({7'h00, irq}, 8'h01);
        rd(SARC_CTRL_ADDR, 8'hD0);
        wr(SARC_STATUS_ADDR, 8'h01);
        chk({7'h00, irq}, 8'h00);
    endtask : t_irq
    task automatic t_restart();
        wr(SARC_CTRL_ADDR, 8'h30);
        repeat (5) @(posedge clk);
        wr(SARC_CTRL_ADDR, 8'h30);
        rd(SARC_STATUS_ADDR, 8'h02);
        wait_idle();
        rd(SARC_STATUS_ADDR, 8'h03);
    endtask : t_restart
    task automatic t_power();
        wr(SARC_CTRL_ADDR, 8'h20);
        chk({6'h00, adc_power, conv_busy}, 8'h00);
        wr(SARC_CTRL_ADDR, 8'h30);
        wr(SARC_CTRL_ADDR, 8'h0F);
        chk({6'h00, adc_power, conv_busy}, 8'h00);
        rd(SARC_CTRL_ADDR, 8'h00);
        wr(SARC_RESULT_ADDR, 8'h55);
        rd(SARC_RESULT_ADDR, vin);
        wr(SARC_CTRL_ADDR, 8'hB0);
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        #1;
        chk({5'h00, irq, conv_busy, adc_power}, 8'h00);
        rd(SARC_CTRL_ADDR, 8'h40);
    endtask : t_power
    task automatic end_sim();
        if (bad_count == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_sim
    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_convert();
        t_irq();
        t_restart();
        t_power();
        end_sim();
    end
    // tests need well under a thousand cycles
    initial begin
        #100000;
        bad_count++;
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
